// ===== dv/adcsq_conv_model.sv
// Purpose: behavioural converter behind the sequencer
// Assumes: one done pulse per start, abort drops the pending one
// Notes: data is inverted every cycle outside a done pulse
`timescale 1ns/1ns
module adcsq_conv_model (
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire [3:0] dly,
  input wire conv_start,
  input wire [2:0] conv_chan,
  input wire conv_special,
  input wire conv_abort,
  // answer
  output reg conv_done,
  output reg [7:0] conv_data
);
  reg [3:0] cnt_r;
  reg [2:0] chan_r;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      chan_r <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 8'h5a;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_abort) begin
        cnt_r <= 4'h0;
      end else if (conv_start) begin
        cnt_r <= dly;
        chan_r <= conv_chan;
      end else if (cnt_r == 4'h1) begin
        cnt_r <= 4'h0;
        conv_done <= 1'b1;
        conv_data <= {4'h3, conv_special, chan_r};
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// ===== dv/adcsq_seq_ctrl_asserts.sv
// Purpose: port assertions for the sequence controller
// Assumes: zero-wait apb, registered converter strobes
// Notes: bound to every instance of the controller
`timescale 1ns/1ns
module adcsq_seq_chk (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // converter and irq
  input wire conv_start,
  input wire [2:0] conv_chan,
  input wire conv_special,
  input wire conv_abort,
  input wire conv_done,
  input wire irq
);
  wire acc = psel && penable;
  wire cw = acc && pwrite && (paddr == 12'h000 || paddr == 12'h004);
  wire rd_irq = acc && !pwrite && paddr == 12'h00c;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_ctrl_start: assert property (cw |-> ##[2:3] conv_start)
    else $error("no start after control write");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start held too long");
  chk_start_gap: assert property (conv_start && !cw |=>
    !conv_start [*2])
    else $error("starts too close");
  chk_abort_pulse: assert property (conv_abort |=> !conv_abort)
    else $error("abort held too long");
  chk_abort_cause: assert property (conv_abort |->
    $past(cw) || $past(cw, 2)) else $error("abort without write");
  chk_chan_hold: assert property ($changed({conv_chan, conv_special})
    |-> conv_start) else $error("channel moved without start");
  chk_irq_clear: assert property (rd_irq && !conv_done
    && !$past(conv_done) |=> !irq) else $error("irq not cleared");
  chk_ctrl_accept: assert property (cw |-> pready && !pslverr)
    else $error("control write refused");
endmodule
bind adcsq_seq_ctrl adcsq_seq_chk adcsq_seq_chk_i (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
  .conv_chan(conv_chan), .conv_special(conv_special),
  .conv_abort(conv_abort), .conv_done(conv_done), .irq(irq));

// ===== dv/adcsq_seq_ctrl_tb.sv
// Purpose: self-checking bench of the sequence controller
// Assumes: converter model stands on the far side
// Notes: external results carry 8'h30 plus channel
`timescale 1ns/1ns
module adcsq_seq_ctrl_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] dly = 4'h1;
  wire [31:0] prdata;
  wire pready, pslverr, conv_start, conv_special, conv_abort;
  wire conv_done, irq;
  wire [2:0] conv_chan;
  wire [7:0] conv_data;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer n_start = 0;
  integer n_abort = 0;
  reg [31:0] rd;
  reg err;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    n_start <= n_start + conv_start;
    n_abort <= n_abort + conv_abort;
  end
  adcsq_seq_ctrl adcsq_seq_ctrl_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_special(conv_special), .conv_abort(conv_abort),
    .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  adcsq_conv_model adcsq_conv_model_i (.mclk(mclk), .rst(rst), .dly(dly),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_special(conv_special), .conv_abort(conv_abort),
    .conv_done(conv_done), .conv_data(conv_data));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_done;
    integer i;
    begin
      rd = 32'h0;
      for (i = 0; i < 60 && rd[8] !== 1'b1; i = i + 1)
        apb(1'b0, 12'h008, 32'h0);
      chk(rd[8], 1'b1);
    end
  endtask
  task chk_res(input [2:0] n, input [7:0] e);
    begin
      apb(1'b0, {7'h01, n, 2'b00}, 32'h0);
      chk(rd, {24'h0, e});
    end
  endtask
  task t_sweep(input l8, input [2:0] s, input [3:0] n);
    integer i;
    begin
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, {25'h0, l8, 3'h2, s});
      chk(err, 1'b0);
      wait_done;
      chk(rd[23:16], (1 << n) - 1);
      for (i = 0; i < n; i = i + 1)
        chk_res(i[2:0], {5'h06, s + i[2:0]});
    end
  endtask
  task t_len(input [31:0] c4, input l8, input [3:0] n);
    integer i;
    begin
      apb(1'b1, 12'h004, {25'h0, l8, 6'h05});
      apb(1'b1, 12'h000, c4);
      wait_done;
      chk(rd[23:16], (1 << n) - 1);
      chk(conv_special, 1'b0);
      chk(conv_chan, 3'h5);
      for (i = 0; i < n; i = i + 1)
        chk_res(i[2:0], 8'h35);
    end
  endtask
  task t_special;
    integer i;
    reg [2:0] c;
    reg [7:0] e;
    begin
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h5c);
      wait_done;
      chk(conv_special, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
        c = 3'h4 + i[2:0];
        e = c == 3'h4 ? 8'hff : c == 3'h6 ? 8'h7f : 8'h00;
        chk_res(i[2:0], e);
      end
    end
  endtask
  task t_scan;
    integer i;
    begin
      dly <= 4'h6;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h22);
      wait_done;
      i = n_start;
      repeat (40) @(posedge mclk);
      chk(n_start - i >= 3, 1);
      i = n_abort;
      apb(1'b1, 12'h004, 32'h15);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[23:8], 16'h0);
      chk(n_abort - i, 1);
      wait_done;
      for (i = 0; i < 4; i = i + 1)
        chk_res(i[2:0], {5'h06, 3'h5 + i[2:0]});
      i = n_start;
      repeat (30) @(posedge mclk);
      chk(n_start, i);
    end
  endtask
  task t_irq;
    begin
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      wait_done;
      @(negedge mclk);
      chk(irq, 1);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd[1:0], 2'h3);
      @(negedge mclk);
      chk(irq, 0);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      wait_done;
      @(negedge mclk);
      chk(irq, 0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd[0], 1);
      apb(1'b1, 12'h014, 32'hffff_ffff);
      chk(err, 1'b1);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b1);
    end
  endtask
  task summarize;
    begin
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    summarize;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_sweep(1'b1, 3'h5, 4'd8);
    t_sweep(1'b0, 3'h6, 4'd4);
    t_len(32'h1, 1'b0, 4'd1);
    t_len(32'h0, 1'b0, 4'd4);
    t_len(32'h1, 1'b1, 4'd8);
    t_special;
    t_scan;
    t_irq;
    summarize;
  end
endmodule

// ===== src/adcsq_chan_decode.v
// Purpose: channel code for one sequence position
// Assumes: position counter counts from zero
// Notes: special codes with top bit low or 111 are reserved
`timescale 1ns/1ns
`include "adcsq_defines.vh"

module adcsq_chan_decode (
  // settings
  input wire channel_sweep_bit,
  input wire special_source_bit,
  input wire [2:0] start_code,
  input wire [2:0] pos,
  // decoded channel
  output wire [2:0] chan_code,
  output wire [7:0] ext_onehot,
  output wire spec_high,
  output wire spec_low,
  output wire spec_mid,
  output wire spec_reserved
);

  // 3-bit add wraps 111 to 000 by itself
  assign chan_code = channel_sweep_bit ? start_code + pos : start_code;
  assign ext_onehot = special_source_bit ? 8'h00 : (8'h01 << chan_code);
  assign spec_high = special_source_bit && chan_code == `ADCSQ_SPEC_HIGH;
  assign spec_low = special_source_bit && chan_code == `ADCSQ_SPEC_LOW;
  assign spec_mid = special_source_bit && chan_code == `ADCSQ_SPEC_MID;
  assign spec_reserved = special_source_bit &&
    !(spec_high || spec_low || spec_mid);

endmodule

// ===== src/adcsq_defines.vh
// Purpose: constants of the conversion-sequence controller
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define ADCSQ_OFS_CTRL4 12'h000
`define ADCSQ_OFS_CTRL5 12'h004
`define ADCSQ_OFS_STAT 12'h008
`define ADCSQ_OFS_IRQ_STAT 12'h00c
`define ADCSQ_OFS_IRQ_MASK 12'h010
`define ADCSQ_OFS_RESULT0 12'h020

// -----------------------------------------------------------------------
// control five field positions
// -----------------------------------------------------------------------
`define ADCSQ_C5_LEN8 6
`define ADCSQ_C5_SCAN 5
`define ADCSQ_C5_SWEEP 4
`define ADCSQ_C5_SPEC 3
`define ADCSQ_C5_SEL_HI 2
`define ADCSQ_C5_SEL_LO 0
// control four: only the one-length bit is kept here
`define ADCSQ_C4_LEN1 0

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define ADCSQ_CTRL4_RST 8'h00
`define ADCSQ_CTRL5_RST 8'h00
`define ADCSQ_MASK_RST 2'h0

// -----------------------------------------------------------------------
// interrupt status bits
// -----------------------------------------------------------------------
`define ADCSQ_IRQ_SEQ 0
`define ADCSQ_IRQ_CONV 1

// -----------------------------------------------------------------------
// special source codes and expected 8-bit results
// -----------------------------------------------------------------------
`define ADCSQ_SPEC_HIGH 3'h4
`define ADCSQ_SPEC_LOW 3'h5
`define ADCSQ_SPEC_MID 3'h6
`define ADCSQ_EXP_HIGH 8'hff
`define ADCSQ_EXP_LOW 8'h00
`define ADCSQ_EXP_MID 8'h7f

// -----------------------------------------------------------------------
// sequence lengths minus one
// -----------------------------------------------------------------------
`define ADCSQ_LAST_ONE 3'h0
`define ADCSQ_LAST_FOUR 3'h3
`define ADCSQ_LAST_EIGHT 3'h7

`endif

// ===== src/adcsq_len_decode.v
// Purpose: sequence length decode
// Assumes: eight-length bit wins over one-length bit
// Notes: gives the last position index of a sequence
`timescale 1ns/1ns
`include "adcsq_defines.vh"

module adcsq_len_decode (
  // length bits
  input wire length_eight_bit,
  input wire length_one_bit,
  // last position
  output reg [2:0] last_pos
);

  always @* begin
    if (length_eight_bit) begin
      last_pos = `ADCSQ_LAST_EIGHT;
    end else if (length_one_bit) begin
      last_pos = `ADCSQ_LAST_ONE;
    end else begin
      last_pos = `ADCSQ_LAST_FOUR;
    end
  end

endmodule

// ===== src/adcsq_seq_ctrl.v
// Purpose: conversion-sequence controller with apb registers
// Assumes: converter answers each start with one conv_done pulse
// Notes: results stored 8-bit; read of irq status clears it
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "adcsq_defines.vh"

module adcsq_seq_ctrl (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // converter side
  output reg conv_start,
  output reg [2:0] conv_chan,
  output reg conv_special,
  output reg conv_abort,
  input wire conv_done,
  input wire [7:0] conv_data,
  // interrupt
  output wire irq
);

  // -----------------------------------------------------------------------
  // states
  // -----------------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] ctrl4_r;
  reg [7:0] ctrl5_r;
  reg [2:0] pos_r;
  reg [2:0] pos_nxt;
  reg seq_done_r;
  reg [7:0] conv_flags_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [7:0] result_r [0:7];
  reg seq_done_nxt;
  reg [7:0] conv_flags_nxt;
  reg [1:0] irq_stat_nxt;
  reg [31:0] rd_mux;
  integer i;

  wire wr_en;
  wire rd_en;
  wire rd_setup;
  wire ctrl_wr;
  wire sel_ctrl4;
  wire sel_ctrl5;
  wire sel_stat;
  wire sel_irq_stat;
  wire sel_irq_mask;
  wire sel_result;
  wire sel_any;
  wire [2:0] last_pos;
  wire [2:0] chan_code;
  wire spec_high;
  wire spec_low;
  wire spec_mid;
  wire spec_reserved;
  wire seq_end;
  wire conv_hit;
  wire conv_evt;
  wire seq_evt;
  wire [7:0] store_data;
  wire [31:0] stat_word;
  wire irq_stat_rd;

  // -----------------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------------
  assign sel_ctrl4 = paddr == `ADCSQ_OFS_CTRL4;
  assign sel_ctrl5 = paddr == `ADCSQ_OFS_CTRL5;
  assign sel_stat = paddr == `ADCSQ_OFS_STAT;
  assign sel_irq_stat = paddr == `ADCSQ_OFS_IRQ_STAT;
  assign sel_irq_mask = paddr == `ADCSQ_OFS_IRQ_MASK;
  // eight aligned result words from the first result offset on
  assign sel_result = {paddr[11:5], 5'h00} == `ADCSQ_OFS_RESULT0 &&
    paddr[1:0] == 2'b00;
  assign sel_any = sel_ctrl4 || sel_ctrl5 || sel_stat || sel_irq_stat ||
    sel_irq_mask || sel_result;

  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign ctrl_wr = wr_en && (sel_ctrl4 || sel_ctrl5);
  // unmapped access: write dropped, read gives zero
  assign pslverr = psel && penable && !sel_any;
  assign irq_stat_rd = rd_en && sel_irq_stat;

  // -----------------------------------------------------------------------
  // decoders
  // -----------------------------------------------------------------------
  adcsq_len_decode u_len (
    .length_eight_bit(ctrl5_r[`ADCSQ_C5_LEN8]),
    .length_one_bit(ctrl4_r[`ADCSQ_C4_LEN1]),
    .last_pos(last_pos)
  );

  adcsq_chan_decode u_chan (
    .channel_sweep_bit(ctrl5_r[`ADCSQ_C5_SWEEP]),
    .special_source_bit(ctrl5_r[`ADCSQ_C5_SPEC]),
    .start_code(ctrl5_r[`ADCSQ_C5_SEL_HI:`ADCSQ_C5_SEL_LO]),
    .pos(pos_r),
    .chan_code(chan_code),
    .ext_onehot(),
    .spec_high(spec_high),
    .spec_low(spec_low),
    .spec_mid(spec_mid),
    .spec_reserved(spec_reserved)
  );

  // -----------------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------------
  assign conv_hit = state_r == ST_WAIT && conv_done;
  assign seq_end = conv_hit && pos_r == last_pos;

  always @* begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    case (state_r)
      ST_IDLE: begin
        pos_nxt = 3'h0;
      end
      ST_START: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done) begin
          state_nxt = ST_START;
          pos_nxt = pos_r + 3'h1;
          if (pos_r == last_pos) begin
            pos_nxt = 3'h0;
            if (!ctrl5_r[`ADCSQ_C5_SCAN]) begin
              state_nxt = ST_IDLE;
            end  // else repeat with same settings
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        pos_nxt = 3'h0;
      end
    endcase
    if (ctrl_wr) begin
      state_nxt = ST_START;
      pos_nxt = 3'h0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      pos_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl4_r <= `ADCSQ_CTRL4_RST;
      ctrl5_r <= `ADCSQ_CTRL5_RST;
    end else begin
      if (wr_en && sel_ctrl4) begin
        ctrl4_r <= pwdata[7:0];
      end
      if (wr_en && sel_ctrl5) begin
        ctrl5_r <= pwdata[7:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // converter strobes
  // -----------------------------------------------------------------------
  // a control write in the start state cancels that start, so start and
  // abort never leave together and the channel moves only with a start
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_chan <= 3'h0;
      conv_special <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      // abort any conversion still running on a control write
      conv_abort <= ctrl_wr && state_r != ST_IDLE;
      conv_start <= state_r == ST_START && !ctrl_wr;
      if (state_r == ST_START && !ctrl_wr) begin
        conv_chan <= chan_code;
        conv_special <= ctrl5_r[`ADCSQ_C5_SPEC];
      end
    end
  end

  // -----------------------------------------------------------------------
  // results and flags
  // -----------------------------------------------------------------------
  // a done that meets a control write belongs to the aborted sequence
  assign conv_evt = conv_hit && !ctrl_wr;
  assign seq_evt = seq_end && !ctrl_wr;

  // special sources get their fixed code; reserved codes store zero
  assign store_data = spec_high ? `ADCSQ_EXP_HIGH :
    spec_low ? `ADCSQ_EXP_LOW :
    spec_mid ? `ADCSQ_EXP_MID :
    spec_reserved ? 8'h00 : conv_data;

  always @* begin
    seq_done_nxt = seq_done_r;
    conv_flags_nxt = conv_flags_r;
    if (ctrl_wr) begin
      seq_done_nxt = 1'b0;
      conv_flags_nxt = 8'h00;
    end else begin
      if (seq_evt) begin
        seq_done_nxt = 1'b1;
      end
      if (conv_evt) begin
        conv_flags_nxt[pos_r] = 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_done_r <= 1'b0;
      conv_flags_r <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        result_r[i] <= 8'h00;
      end
    end else begin
      seq_done_r <= seq_done_nxt;
      conv_flags_r <= conv_flags_nxt;
      if (conv_evt) begin
        result_r[pos_r] <= store_data;
      end
    end
  end

  // -----------------------------------------------------------------------
  // interrupt status: set wins over read-clear
  // -----------------------------------------------------------------------
  // a read clears only the bits it reported at its setup edge, so an
  // event landing between setup and access stays pending
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (irq_stat_rd) begin
      irq_stat_nxt = irq_stat_r & ~prdata[1:0];
    end
    if (seq_evt) begin
      irq_stat_nxt[`ADCSQ_IRQ_SEQ] = 1'b1;
    end
    if (conv_evt) begin
      irq_stat_nxt[`ADCSQ_IRQ_CONV] = 1'b1;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= `ADCSQ_MASK_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en && sel_irq_mask) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // -----------------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------------
  assign stat_word = {5'h00, pos_r, conv_flags_r, 7'h00, seq_done_r, 6'h00,
    state_r};

  always @* begin
    rd_mux = 32'h00000000;
    if (sel_ctrl4) begin
      rd_mux = {24'h000000, ctrl4_r};
    end else if (sel_ctrl5) begin
      rd_mux = {24'h000000, ctrl5_r};
    end else if (sel_stat) begin
      rd_mux = stat_word;
    end else if (sel_irq_stat) begin
      rd_mux = {30'h00000000, irq_stat_r};
    end else if (sel_irq_mask) begin
      rd_mux = {30'h00000000, irq_mask_r};
    end else if (sel_result) begin
      rd_mux = {24'h000000, result_r[paddr[4:2]]};
    end
  end

  // loaded at the setup edge, stands through the access phase
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule
